// file: core/bus_filter.sv
// Purpose: synchronise and deglitch the two serial bus lines
// Assumes: lines are asynchronous to i_clk
// Notes: a level must hold for the window before it is accepted
module bus_filter #(
  parameter int WINDOW = pot_pkg::GLITCH_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // raw and clean lines
  input wire pot_pkg::bus_lines_s i_raw,
  output pot_pkg::bus_lines_s o_clean
);
  localparam int CW = $clog2(WINDOW + 1);
  initial begin
    if (WINDOW < 1) $error("window must be at least one cycle");
  end
  pot_pkg::bus_lines_s meta;
  pot_pkg::bus_lines_s sync;
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      meta <= 2'b11;
      sync <= 2'b11;
    end else begin
      meta <= i_raw;
      sync <= meta;
    end
  end
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_line
      logic [CW-1:0] cnt;
      logic level;
      always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
          cnt <= '0;
          level <= 1'b1;
        end else if (sync[g] == level) begin
          cnt <= '0;
        end else if (cnt == CW'(WINDOW - 1)) begin
          cnt <= '0;
          level <= sync[g];
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
      assign o_clean[g] = level;
    end
  endgenerate
endmodule

// file: core/pot_pkg.sv
// Purpose: constants and carriers for the i2c wiper control block
// Assumes: 200 MHz i_clk; bus pins arrive asynchronously
// Notes: register map offsets are byte pointers on the serial bus
// How it works
// - address is 01010 plus two select pins
// - fast-mode and standard-mode bus timing both served
// - bus pulses under 50 ns are ignored
// - nonvolatile write starts after stop, lasts 20 ms
// - power control bit 0 enters standby
// - copy stored values, then report recall done
// - exactly one of three wiper modes active
// - default mode wiper follows volatile and stored value
// - table modes derive wiper from temperature
// - 7-bit wiper value selects one of 128 taps
// - update and adder bits choose the mode
// - shadow inhibit keeps stored value unchanged
// - power-up loads stored value into wiper
package pot_pkg;
  localparam logic [4:0] ADDR_FIXED = 5'h0a;
  localparam logic [7:0] OFS_WIPER_IV = 8'h00;
  localparam logic [7:0] OFS_CR0 = 8'h02;
  localparam logic [7:0] OFS_NV_CFG = 8'h03;
  localparam logic [7:0] OFS_LUT_ADDR = 8'h08;
  localparam logic [7:0] OFS_WIPER_LUT = 8'h09;
  localparam logic [7:0] OFS_PWR_CTL = 8'h0a;
  localparam logic [7:0] OFS_TEMP = 8'h0c;
  localparam logic [7:0] OFS_VCC = 8'h0e;
  localparam logic [6:0] WIPER_RESET = 7'h40;
  localparam int SHADOW_INHIBIT_BIT = 7;
  localparam int UPDATE_MODE_BIT = 0;
  localparam int ADDER_MODE_BIT = 1;
  localparam int STANDBY_BIT = 0;
  localparam int CLK_PERIOD_PS = 5000;
  localparam int GLITCH_NS = 50;
  localparam int GLITCH_CYC = (GLITCH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int NV_WRITE_MS = 20;
  localparam int NV_WRITE_CYC = NV_WRITE_MS * (1000000000 / CLK_PERIOD_PS);
  localparam int RECALL_CYC = 16;

  typedef enum logic [1:0] {
    MODE_DEFAULT = 2'b00,
    MODE_LUT = 2'b01,
    MODE_LUT_ADD = 2'b10
  } wiper_mode_e;

  typedef struct packed {
    logic scl;
    logic sda;
  } bus_lines_s;

  typedef struct packed {
    logic [6:0] stored_iv;
    logic [1:0] nv_cfg;
  } nv_image_s;
endpackage

// file: core/pot_wiper_ctrl.sv
// Purpose: serial target, register file and wiper control
// Assumes: nonvolatile image is held in flops; temperature is an input
// Notes: table arithmetic lives outside; its result comes on i_table_wiper
module pot_wiper_ctrl #(
  parameter int NV_WRITE_CYCLES = pot_pkg::NV_WRITE_CYC,
  parameter int RECALL_CYCLES = pot_pkg::RECALL_CYC
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // serial bus
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_oe,
  // address select pins
  input wire logic i_addr_select_low,
  input wire logic i_addr_select_high,
  // temperature path
  input wire logic [7:0] i_temp,
  input wire logic [7:0] i_vcc,
  input wire logic i_temp_valid,
  input wire logic [6:0] i_table_wiper,
  // status and wiper
  output logic [6:0] o_tap,
  output logic [1:0] o_mode,
  output logic [7:0] o_lut_addr,
  output logic o_standby,
  output logic o_recall_done,
  output logic o_nv_busy
);
  initial begin
    if (NV_WRITE_CYCLES < 1 || RECALL_CYCLES < 1) $error("counts must be positive");
  end

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ACK = 3'b010,
    ST_WRITE = 3'b011,
    ST_READ = 3'b100,
    ST_RACK = 3'b101
  } bus_state_e;

  pot_pkg::bus_lines_s raw_lines;
  pot_pkg::bus_lines_s clean;
  assign raw_lines = '{scl: i_scl, sda: i_sda};
  bus_filter u_filter (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_raw(raw_lines),
    .o_clean(clean)
  );

  // edge and condition detection on the filtered lines
  logic scl_q, sda_q;
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= clean.scl;
      sda_q <= clean.sda;
    end
  end
  logic scl_rise, scl_fall, start_cond, stop_cond;
  assign scl_rise = clean.scl && !scl_q;
  assign scl_fall = !clean.scl && scl_q;
  // filtered sampling covers both standard and fast timing
  assign start_cond = clean.scl && scl_q && sda_q && !clean.sda;
  assign stop_cond = clean.scl && scl_q && !sda_q && clean.sda;

  // address pins pass two flops
  logic [1:0] asel_meta, asel;
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      asel_meta <= 2'b00;
      asel <= 2'b00;
    end else begin
      asel_meta <= {i_addr_select_high, i_addr_select_low};
      asel <= asel_meta;
    end
  end

  // registers
  pot_pkg::nv_image_s nv_image;
  logic [6:0] wiper;
  logic [7:0] cr0;
  logic [1:0] nv_cfg;
  logic [7:0] power_control_reg;
  logic [7:0] lut_addr;
  logic recalled;
  logic [$clog2(RECALL_CYCLES+1)-1:0] recall_cnt;

  function automatic pot_pkg::wiper_mode_e mode_of(input logic [1:0] cfg);
    if (!cfg[pot_pkg::UPDATE_MODE_BIT]) return pot_pkg::MODE_DEFAULT;
    if (cfg[pot_pkg::ADDER_MODE_BIT]) return pot_pkg::MODE_LUT_ADD;
    return pot_pkg::MODE_LUT;
  endfunction

  pot_pkg::wiper_mode_e mode;
  assign mode = mode_of(nv_cfg);

  // serial engine
  bus_state_e state;
  logic [7:0] shift;
  logic [3:0] bit_cnt;
  logic rw_read, first_byte, drive_low;
  logic [7:0] pointer;
  logic wr_stb;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  logic addr_match;
  assign addr_match = shift[7:1] == {pot_pkg::ADDR_FIXED, asel};

  always_comb begin
    case (pointer)
      pot_pkg::OFS_WIPER_IV: rd_data = (mode == pot_pkg::MODE_DEFAULT) ?
        {1'b0, wiper} : {1'b0, nv_image.stored_iv};
      pot_pkg::OFS_CR0: rd_data = cr0;
      pot_pkg::OFS_NV_CFG: rd_data = {6'h00, nv_cfg};
      pot_pkg::OFS_LUT_ADDR: rd_data = lut_addr;
      pot_pkg::OFS_WIPER_LUT: rd_data = {1'b0, wiper};
      pot_pkg::OFS_PWR_CTL: rd_data = power_control_reg;
      pot_pkg::OFS_TEMP: rd_data = i_temp;
      pot_pkg::OFS_VCC: rd_data = i_vcc;
      default: rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      state <= ST_IDLE;
      shift <= 8'h00;
      bit_cnt <= 4'h0;
      rw_read <= 1'b0;
      first_byte <= 1'b0;
      drive_low <= 1'b0;
      pointer <= 8'h00;
      wr_stb <= 1'b0;
      wr_data <= 8'h00;
    end else begin
      wr_stb <= 1'b0;
      if (start_cond) begin
        state <= ST_ADDR;
        bit_cnt <= 4'h0;
        drive_low <= 1'b0;
      end else if (stop_cond) begin
        state <= ST_IDLE;
        drive_low <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: drive_low <= 1'b0;
          ST_ADDR: begin
            if (scl_rise) begin
              shift <= {shift[6:0], clean.sda};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              if (addr_match && recalled) begin
                state <= ST_ACK;
                rw_read <= shift[0];
                first_byte <= 1'b1;
                drive_low <= 1'b1;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (rw_read) begin
                state <= ST_READ;
                shift <= rd_data;
                drive_low <= !rd_data[7];
              end else begin
                state <= ST_WRITE;
                drive_low <= 1'b0;
              end
            end
          end
          ST_WRITE: begin
            if (scl_rise) begin
              shift <= {shift[6:0], clean.sda};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              state <= ST_ACK;
              drive_low <= 1'b1;
              first_byte <= 1'b0;
              if (first_byte) begin
                pointer <= shift;
              end else begin
                wr_stb <= 1'b1;
                wr_data <= shift;
                pointer <= pointer + 8'h01;
              end
            end
          end
          ST_READ: begin
            if (scl_fall) begin
              if (bit_cnt == 4'h7) begin
                state <= ST_RACK;
                drive_low <= 1'b0;
                pointer <= pointer + 8'h01;
              end else begin
                shift <= {shift[6:0], 1'b0};
                drive_low <= !shift[6];
              end
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              rw_read <= !clean.sda;
            end else if (scl_fall) begin
              if (rw_read) begin
                state <= ST_READ;
                bit_cnt <= 4'h0;
                shift <= rd_data;
                drive_low <= !rd_data[7];
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // register writes and nonvolatile staging
  logic nv_pending;
  pot_pkg::nv_image_s nv_staged;
  logic [$clog2(NV_WRITE_CYCLES+1)-1:0] nv_cnt;
  logic nv_busy;

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      cr0 <= 8'h00;
      power_control_reg <= 8'h00;
      lut_addr <= 8'h00;
      nv_pending <= 1'b0;
      nv_staged <= '0;
    end else begin
      if (!nv_pending && !nv_busy) begin
        nv_staged <= '{stored_iv: nv_image.stored_iv, nv_cfg: nv_cfg};
      end
      if (wr_stb && !nv_busy) begin
        case (pointer - 8'h01)
          pot_pkg::OFS_WIPER_IV: begin
            if (!cr0[pot_pkg::SHADOW_INHIBIT_BIT]) begin
              nv_staged.stored_iv <= wr_data[6:0];
              nv_pending <= 1'b1;
            end
          end
          pot_pkg::OFS_CR0: cr0 <= wr_data;
          pot_pkg::OFS_NV_CFG: begin
            nv_staged.nv_cfg <= wr_data[1:0];
            nv_pending <= 1'b1;
          end
          pot_pkg::OFS_LUT_ADDR: lut_addr <= wr_data;
          pot_pkg::OFS_PWR_CTL: power_control_reg <= wr_data;
          default: ;
        endcase
      end
      if (stop_cond && nv_pending) begin
        nv_pending <= 1'b0;
      end
    end
  end

  // nonvolatile write timer, started by stop
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      nv_busy <= 1'b0;
      nv_cnt <= '0;
    end else if (stop_cond && nv_pending && !nv_busy) begin
      nv_busy <= 1'b1;
      nv_cnt <= '0;
    end else if (nv_busy) begin
      if (nv_cnt == $bits(nv_cnt)'(NV_WRITE_CYCLES - 1)) begin
        nv_busy <= 1'b0;
      end else begin
        nv_cnt <= nv_cnt + 1'b1;
      end
    end
  end

  // nonvolatile image: kept across the block reset in a real part
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      nv_image <= '{stored_iv: pot_pkg::WIPER_RESET, nv_cfg: 2'b00};
    end else if (nv_busy && nv_cnt == $bits(nv_cnt)'(NV_WRITE_CYCLES - 1)) begin
      nv_image <= nv_staged;
    end
  end

  // power-up recall, then wiper ownership by mode
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      recalled <= 1'b0;
      recall_cnt <= '0;
      nv_cfg <= 2'b00;
      wiper <= 7'h00;
    end else if (!recalled) begin
      wiper <= nv_image.stored_iv;
      nv_cfg <= nv_image.nv_cfg;
      if (recall_cnt == $bits(recall_cnt)'(RECALL_CYCLES - 1)) begin
        recalled <= 1'b1;
      end else begin
        recall_cnt <= recall_cnt + 1'b1;
      end
    end else begin
      if (nv_busy && nv_cnt == $bits(nv_cnt)'(NV_WRITE_CYCLES - 1)) begin
        nv_cfg <= nv_staged.nv_cfg;
      end
      if (mode == pot_pkg::MODE_DEFAULT) begin
        if (wr_stb && !nv_busy && (pointer - 8'h01) == pot_pkg::OFS_WIPER_IV) begin
          wiper <= wr_data[6:0];
        end
      end else if (i_temp_valid) begin
        wiper <= i_table_wiper;
      end else if (wr_stb && (pointer - 8'h01) == pot_pkg::OFS_WIPER_LUT) begin
        wiper <= wr_data[6:0];
      end
    end
  end

  // outputs
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_sda_oe <= 1'b0;
      o_tap <= 7'h00;
      o_mode <= pot_pkg::MODE_DEFAULT;
      o_lut_addr <= 8'h00;
      o_standby <= 1'b0;
      o_recall_done <= 1'b0;
      o_nv_busy <= 1'b0;
    end else begin
      o_sda_oe <= drive_low;
      o_tap <= wiper;
      o_mode <= mode;
      o_lut_addr <= lut_addr;
      o_standby <= power_control_reg[pot_pkg::STANDBY_BIT];
      o_recall_done <= recalled;
      o_nv_busy <= nv_busy;
    end
  end
endmodule

// file: tb/i2c_host.sv
// Purpose: bus controller model facing the wiper block
// Assumes: pull-up on sda only, scl driven high and low; 160 ns bit period
// Notes: lines move by nba just after an i_clk rise
module i2c_host (
  // clock
  input wire logic i_clk,
  // bus
  input wire logic i_sda_line,
  output logic o_scl,
  output logic o_sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic ack = 1'b0;
  logic [7:0] rd = 8'h00;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
  end
  // quarter bit of 40 ns; scl low and high each 80 ns
  task automatic q(input logic c, input logic d);
    @(posedge i_clk);
    o_scl <= c;
    o_sda_low <= ~d;
    repeat (7) @(posedge i_clk);
  endtask
  task automatic bit_io(input logic d, output logic s);
    q(1'b0, d);
    q(1'b1, d);
    s = i_sda_line;
    q(1'b1, d);
    q(1'b0, d);
  endtask
  // sda is released while scl is still low, so a repeated start is never seen as a stop
  task automatic start();
    q(o_scl, 1'b1);
    q(1'b1, 1'b1);
    q(1'b1, 1'b1);
    q(1'b1, 1'b0);
    q(1'b0, 1'b0);
  endtask
  task automatic stop();
    q(1'b0, 1'b0);
    q(1'b1, 1'b0);
    q(1'b1, 1'b1);
    q(1'b1, 1'b1);
  endtask
  task automatic send(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask
  task automatic recv(input logic nack);
    logic s;
    for (int i = 0; i < 8; i++) begin
      bit_io(1'b1, s);
      rd = {rd[6:0], s};
    end
    bit_io(nack, s);
  endtask
  // 40 ns clock spike, under the suppression width
  task automatic glitch();
    q(1'b0, 1'b1);
    q(1'b0, 1'b1);
    @(posedge i_clk);
    o_scl <= 1'b1;
    repeat (8) @(posedge i_clk);
    o_scl <= 1'b0;
  endtask
endmodule

// file: tb/pot_wiper_ctrl_assertions.sv
// Purpose: port checks for the wiper control block
// Assumes: one clock domain, sync active-low reset
// Notes: bound into the design below
module pot_wiper_ctrl_assertions #(
  parameter int NV_WRITE_CYCLES = 200
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // watched ports
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic o_sda_oe,
  input wire logic i_temp_valid,
  input wire logic [6:0] i_table_wiper,
  input wire logic [6:0] o_tap,
  input wire logic [1:0] o_mode,
  input wire logic o_recall_done,
  input wire logic o_nv_busy
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);
  int busy_len;
  always_ff @(posedge i_clk) begin
    if (!i_nrst || !o_nv_busy) begin
      busy_len <= 0;
    end else begin
      busy_len <= busy_len + 1;
    end
  end
  sequence s_recall_quiet;
    !o_recall_done [*8];
  endsequence
  sequence s_table_pulse;
    o_mode != 2'b00 && i_temp_valid && o_recall_done;
  endsequence
  a_mode_legal: assert property (o_mode != 2'b11)
    else $error("mode code out of range");
  a_recall_wait: assert property ($rose(i_nrst) |-> s_recall_quiet)
    else $error("recall reported too early");
  a_recall_kept: assert property (o_recall_done |=> o_recall_done)
    else $error("recall done dropped");
  a_ack_recall: assert property (!o_recall_done |-> !o_sda_oe)
    else $error("bus answered before recall");
  a_oe_scl_low: assert property ($changed(o_sda_oe) |-> !i_scl)
    else $error("data moved while clock high");
  a_busy_max: assert property (busy_len <= NV_WRITE_CYCLES)
    else $error("write busy too long");
  a_busy_min: assert property ($fell(o_nv_busy) |-> $past(busy_len) == NV_WRITE_CYCLES - 1)
    else $error("write busy too short");
  a_busy_stop: assert property ($rose(o_nv_busy) |-> i_scl && i_sda)
    else $error("write began with bus active");
  a_table_load: assert property (s_table_pulse |-> ##[1:2] o_tap == i_table_wiper)
    else $error("table result not on wiper");
  a_default_temp: assert property (o_mode == 2'b00 && i_temp_valid |=> $stable(o_tap))
    else $error("wiper moved by table in default mode");
endmodule

bind pot_wiper_ctrl pot_wiper_ctrl_assertions #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) u_chk (
  .i_clk, .i_nrst, .i_scl, .i_sda, .o_sda_oe, .i_temp_valid,
  .i_table_wiper, .o_tap, .o_mode, .o_recall_done, .o_nv_busy
);

// file: tb/pot_wiper_ctrl_bench.sv
// Purpose: self-checking bench for the wiper control block
// Assumes: short write count so the run stays brief
// Notes: drivers queue expectations; a watcher compares
module pot_wiper_ctrl_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NV = 200;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic sel_lo = 1'b0;
  logic sel_hi = 1'b0;
  logic [7:0] temp = 8'h00;
  logic [7:0] vcc = 8'h00;
  logic t_valid = 1'b0;
  logic [6:0] t_wiper = 7'h00;
  logic scl, sda_low, sda_oe, sda_line, standby, recall_done, nv_busy;
  logic [6:0] tap;
  logic [1:0] mode;
  logic [7:0] lut_addr;
  logic [7:0] seen[8];
  string names[8] = '{"tap", "mode", "standby", "busy", "ack", "rdata", "recall", "lut_addr"};
  logic [7:0] cfgs[3] = '{8'h01, 8'h03, 8'h02};
  logic [7:0] modes[3] = '{8'h01, 8'h02, 8'h00};
  logic [7:0] exp_q[$];
  int which_q[$];
  int n_errors = 0;
  int checks_done = 0;
  int seed = 32'h58b4_ffe6;
  logic [7:0] v;
  always #2.5 i_clk = ~i_clk;
  assign sda_line = ~(sda_low | sda_oe);
  assign seen[0] = {1'b0, tap};
  assign seen[1] = {6'h00, mode};
  assign seen[2] = {7'h00, standby};
  assign seen[3] = {7'h00, nv_busy};
  assign seen[4] = {7'h00, u_i2c_host.ack};
  assign seen[5] = u_i2c_host.rd;
  assign seen[6] = {7'h00, recall_done};
  assign seen[7] = lut_addr;
  pot_wiper_ctrl #(.NV_WRITE_CYCLES(NV), .RECALL_CYCLES(16)) u_pot_wiper_ctrl (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_scl(scl), .i_sda(sda_line), .o_sda_oe(sda_oe),
    .i_addr_select_low(sel_lo), .i_addr_select_high(sel_hi), .i_temp(temp), .i_vcc(vcc),
    .i_temp_valid(t_valid), .i_table_wiper(t_wiper), .o_tap(tap), .o_mode(mode),
    .o_lut_addr(lut_addr), .o_standby(standby), .o_recall_done(recall_done), .o_nv_busy(nv_busy)
  );
  i2c_host u_i2c_host (.i_clk(i_clk), .i_sda_line(sda_line), .o_scl(scl), .o_sda_low(sda_low));
  task automatic check(input string what, input logic [7:0] got, input logic [7:0] want);
    checks_done++;
    if (got !== want) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", what, want, got);
    end
  endtask
  // index popped first: argument evaluation order is not fixed
  always @(negedge i_clk) begin
    int w;
    while (exp_q.size() > 0) begin
      w = which_q.pop_front();
      check(names[w], seen[w], exp_q.pop_front());
    end
  end
  task automatic close_out();
    if (n_errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic expect_val(input int which, input logic [7:0] want);
    exp_q.push_back(want);
    which_q.push_back(which);
  endtask
  task automatic wait_for(input int which, input logic [7:0] want, input int limit);
    int k;
    k = 0;
    while (seen[which] !== want && k < limit) begin
      @(posedge i_clk);
      k++;
    end
    if (seen[which] !== want) begin
      check(names[which], seen[which], want);
      close_out();
    end
  endtask
  function automatic logic [7:0] adr(input logic rw);
    return {pot_pkg::ADDR_FIXED, sel_hi, sel_lo, rw};
  endfunction
  task automatic sendk(input logic [7:0] b, input logic a);
    u_i2c_host.send(b);
    expect_val(4, {7'h00, a});
  endtask
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    u_i2c_host.start();
    sendk(adr(1'b0), 1'b1);
    sendk(ptr, 1'b1);
    sendk(d, 1'b1);
    expect_val(3, 8'h00);
    u_i2c_host.stop();
  endtask
  task automatic rd(input logic [7:0] ptr, input logic [7:0] want);
    u_i2c_host.start();
    sendk(adr(1'b0), 1'b1);
    sendk(ptr, 1'b1);
    u_i2c_host.start();
    sendk(adr(1'b1), 1'b1);
    u_i2c_host.recv(1'b1);
    expect_val(5, want);
    u_i2c_host.stop();
  endtask
  task automatic pulse(input logic [6:0] w);
    @(posedge i_clk);
    t_wiper <= w;
    t_valid <= 1'b1;
    @(posedge i_clk);
    t_valid <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask
  task automatic settle();
    wait_for(3, 8'h01, 20);
    wait_for(3, 8'h00, NV + 50);
  endtask
  initial begin
    temp <= 8'($random(seed));
    vcc <= 8'($random(seed));
    repeat (8) @(posedge i_clk);
    i_nrst <= 1'b1;
    wait_for(6, 8'h01, 100);
    pulse(7'($random(seed)));
    expect_val(0, 8'h40);
    expect_val(1, 8'h00);
    expect_val(2, 8'h00);
    for (int p = 0; p < 4; p++) begin
      {sel_hi, sel_lo} <= p[1:0];  // pins held across each frame
      repeat (20) @(posedge i_clk);
      for (int a = 0; a < 4; a++) begin
        u_i2c_host.start();
        sendk({pot_pkg::ADDR_FIXED, a[1:0], 1'b0}, a == p);
        u_i2c_host.stop();
      end
    end
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 8'h7f : (i == 1) ? 8'h00 : {1'b0, 7'($random(seed))};
      wr(8'h00, v);
      expect_val(0, v);
      settle();
      rd(8'h00, v);
    end
    rd(8'h0c, temp);
    rd(8'h0e, vcc);
    v = 8'($random(seed));
    wr(8'h08, v);
    expect_val(7, v);
    wr(8'h02, 8'h80);
    wr(8'h00, 8'h15);
    repeat (20) @(posedge i_clk);
    expect_val(3, 8'h00);
    expect_val(0, 8'h15);
    wr(8'h02, 8'h00);
    wr(8'h0a, 8'h01);
    expect_val(2, 8'h01);
    wr(8'h0a, 8'hfe);
    expect_val(2, 8'h00);
    u_i2c_host.start();
    sendk(adr(1'b0), 1'b1);
    sendk(8'h00, 1'b1);
    u_i2c_host.glitch();
    sendk(8'h2a, 1'b1);
    u_i2c_host.stop();
    expect_val(0, 8'h2a);
    settle();
    for (int i = 0; i < 3; i++) begin
      wr(8'h03, cfgs[i]);
      settle();
      expect_val(1, modes[i]);
      if (i < 2) begin
        pulse(7'($random(seed)));
        expect_val(0, {1'b0, t_wiper});
      end
    end
    repeat (4) @(posedge i_clk);
    close_out();
  end
endmodule
